// ### common/gpp_pkg.sv
/*
 * Constants for the general purpose port block: register offsets,
 * widths, field positions and reset values.
 * Assumes an 8-bit register port with a 6-bit byte address.
 */
package gpp_pkg;
   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int AW  = 6;
   localparam int DW  = 8;
   localparam int P2W = 3;
   localparam int CHW = 3;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [AW-1:0] OFS_P1_LATCH = 6'h01;
   localparam logic [AW-1:0] OFS_P2_LATCH = 6'h02;
   localparam logic [AW-1:0] OFS_P3_LATCH = 6'h03;
   localparam logic [AW-1:0] OFS_P4_LATCH = 6'h04;
   localparam logic [AW-1:0] OFS_P2_PINS  = 6'h0a;
   localparam logic [AW-1:0] OFS_P1_DIR   = 6'h0d;
   localparam logic [AW-1:0] OFS_P3_DIR   = 6'h0e;
   localparam logic [AW-1:0] OFS_P4_DIR   = 6'h0f;
   localparam logic [AW-1:0] OFS_CONV1    = 6'h1c;
   localparam logic [AW-1:0] OFS_CLKMODE  = 6'h20;

   // -----------------------------------------------------------------
   // Fields and reset values
   // -----------------------------------------------------------------
   localparam int ANALOG_INPUT_DISABLE_BIT  = 4;
   localparam int CHSEL_LSB  = 0;
   localparam int DUAL_BIT   = 0;
   localparam int OSC_IN_BIT = 1;
   localparam int OSC_OUT_BIT = 2;
   localparam int INT_BIT    = 0;

   localparam logic [DW-1:0]  ZERO_BYTE  = 8'h00;
   localparam logic [DW-1:0]  ONES_BYTE  = 8'hff;
   localparam logic [DW-1:0]  RST_DIR    = 8'h00;
   localparam logic [DW-1:0]  RST_LATCH  = 8'h00;
   localparam logic [P2W-1:0] RST_P2     = 3'h7;
   localparam logic [DW-1:0]  RST_CONV1  = 8'h10;
   localparam logic [DW-1:0]  RST_MODE   = 8'h00;
endpackage

// ### rtl/gpp_ports.sv
/*
 * Ports one to four: direction registers, output latches, pin
 * read-back, analog takeover of port three, slow oscillator pins and
 * the falling-edge interrupt request of port two bit zero.
 * Assumes pin inputs are synchronous to REF_CLK and that pads merge
 * OUT and OE into the wire level.
 */
// The implementer's own choices: the plain strobed port and the register addresses.
// Functional notes
// RULE1: Port one direction bit 0 is input, 1 drives the pin from latch.
// RULE2: Reset clears port one directions and latches to zero.
// RULE3: Latch writes on ports one, three, four happen whatever direction holds.
// RULE4: Reads give pin level for inputs and latch for outputs.
// RULE5: Read-modify-write stores the whole read byte, input pins included.
// RULE6: Software presets latch to one, then direction, for timer outputs.
// RULE7: Port two has three bits whose latches reset to one.
// RULE8: Software keeps port two latch at one for inputs and alternates.
// RULE9: Dual clock mode gives port two bits one, two to the oscillator.
// RULE10: A falling edge on port two bit zero raises the interrupt request.
// RULE11: Port two latch and pins read apart; upper bits read zero.
// RULE12: Reset clears port three directions and sets analog disable.
// RULE13: With analog enabled, selected port three pin is analog only.
// RULE14: Selected analog pin reads back as its digital level.
// RULE15: Software avoids port three output activity during conversion.
// RULE16: Port four direction bit 0 is input, 1 is output.
// RULE17: Reset clears port four directions and latches to zero.
// RULE18: Undirected pins without alternate claim keep drivers off.
module gpp_ports
(
   input  wire logic                 REF_CLK,
   input  wire logic                 RESET,
   input  wire logic [gpp_pkg::AW-1:0]  ADDR,
   input  wire logic [gpp_pkg::DW-1:0]  WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output logic      [gpp_pkg::DW-1:0]  RDATA,
   input  wire logic [gpp_pkg::DW-1:0]  P1_IN,
   output logic      [gpp_pkg::DW-1:0]  P1_OUT,
   output logic      [gpp_pkg::DW-1:0]  P1_OE,
   input  wire logic [gpp_pkg::DW-1:0]  P1_ALT_EN,
   input  wire logic [gpp_pkg::DW-1:0]  P1_ALT_VAL,
   input  wire logic [gpp_pkg::P2W-1:0] P2_IN,
   output logic      [gpp_pkg::P2W-1:0] P2_OUT,
   output logic      [gpp_pkg::P2W-1:0] P2_OE,
   input  wire logic [gpp_pkg::DW-1:0]  P3_IN,
   output logic      [gpp_pkg::DW-1:0]  P3_OUT,
   output logic      [gpp_pkg::DW-1:0]  P3_OE,
   input  wire logic [gpp_pkg::DW-1:0]  P4_IN,
   output logic      [gpp_pkg::DW-1:0]  P4_OUT,
   output logic      [gpp_pkg::DW-1:0]  P4_OE,
   output logic      [gpp_pkg::DW-1:0]  ANALOG_SEL,
   output logic                      SLOW_OSC_EN,
   output logic                      SLOW_OSC_IN,
   output logic                      EXT_INT_REQ
);
   import gpp_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [DW-1:0]  port_one_direction;
   logic [DW-1:0]  port_three_direction;
   logic [DW-1:0]  port_four_direction;
   logic [DW-1:0]  port_one_latch;
   logic [P2W-1:0] port_two_output_latch;
   logic [DW-1:0]  port_three_output_latch;
   logic [DW-1:0]  port_four_latch;
   logic [DW-1:0]  converter_control_one;
   logic [DW-1:0]  clock_mode;
   logic           p20_prev;
   logic [DW-1:0]  next_rdata;
   logic [DW-1:0]  next_ana;
   logic [CHW-1:0] chan;
   logic           analog_on;
   logic           dual_mode;

   assign chan      = converter_control_one[CHSEL_LSB +: CHW];
   assign analog_on = ~converter_control_one[ANALOG_INPUT_DISABLE_BIT];
   assign dual_mode = clock_mode[DUAL_BIT];

   // Input bits show the pin, output bits the latch
   function automatic logic [DW-1:0] mix(input logic [DW-1:0] dir,
                                         input logic [DW-1:0] lat,
                                         input logic [DW-1:0] pin);
      mix = (dir & lat) | (~dir & pin);
   endfunction

   function automatic logic wr_hit(input logic [AW-1:0] ofs);
      wr_hit = WR && (ADDR == ofs);
   endfunction

   // -----------------------------------------------------------------
   // Direction registers
   // -----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         port_one_direction   <= RST_DIR; // RULE2
         port_three_direction <= RST_DIR; // RULE12
         port_four_direction  <= RST_DIR; // RULE17
      end else begin
         if (wr_hit(OFS_P1_DIR)) port_one_direction <= WDATA; // RULE1
         if (wr_hit(OFS_P3_DIR)) port_three_direction <= WDATA;
         if (wr_hit(OFS_P4_DIR)) port_four_direction <= WDATA; // RULE16
      end
   end

   // -----------------------------------------------------------------
   // Output latches
   // -----------------------------------------------------------------
   // Whole-byte store: a bit-set on a mixed port copies sampled input
   // levels into the input bits' latches, as the read returned them.
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         port_one_latch          <= RST_LATCH; // RULE2
         port_two_output_latch   <= RST_P2; // RULE7
         port_three_output_latch <= RST_LATCH;
         port_four_latch         <= RST_LATCH; // RULE17
      end else begin
         if (wr_hit(OFS_P1_LATCH)) port_one_latch <= WDATA; // RULE3 RULE5
         if (wr_hit(OFS_P2_LATCH)) port_two_output_latch <= WDATA[P2W-1:0];
         if (wr_hit(OFS_P3_LATCH)) port_three_output_latch <= WDATA; // RULE3
         if (wr_hit(OFS_P4_LATCH)) port_four_latch <= WDATA; // RULE3
      end
   end

   // -----------------------------------------------------------------
   // Converter control and clock mode
   // -----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         converter_control_one <= RST_CONV1; // RULE12
         clock_mode            <= RST_MODE;
      end else begin
         if (wr_hit(OFS_CONV1)) converter_control_one <= WDATA;
         if (wr_hit(OFS_CLKMODE)) clock_mode <= WDATA;
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   always_comb begin
      next_ana = ZERO_BYTE;
      if (analog_on) next_ana[chan] = 1'b1; // RULE13
   end

   always_comb begin
      next_rdata = ZERO_BYTE;
      if (!RD) begin
         next_rdata = ZERO_BYTE;
      end else if (ADDR == OFS_P1_LATCH) begin
         next_rdata = mix(port_one_direction, port_one_latch, P1_IN); // RULE4
      end else if (ADDR == OFS_P2_LATCH) begin
         next_rdata[P2W-1:0] = port_two_output_latch; // RULE11
      end else if (ADDR == OFS_P2_PINS) begin
         next_rdata[P2W-1:0] = P2_IN; // RULE11
      end else if (ADDR == OFS_P3_LATCH) begin
         // Analog pin reads its threshold level, not the latch
         next_rdata = mix(port_three_direction & ~next_ana,
                          port_three_output_latch, P3_IN); // RULE4 RULE14
      end else if (ADDR == OFS_P4_LATCH) begin
         next_rdata = mix(port_four_direction, port_four_latch, P4_IN); // RULE4
      end else if (ADDR == OFS_P1_DIR) begin
         next_rdata = port_one_direction;
      end else if (ADDR == OFS_P3_DIR) begin
         next_rdata = port_three_direction;
      end else if (ADDR == OFS_P4_DIR) begin
         next_rdata = port_four_direction;
      end else if (ADDR == OFS_CONV1) begin
         next_rdata = converter_control_one;
      end else if (ADDR == OFS_CLKMODE) begin
         next_rdata = clock_mode;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) RDATA <= ZERO_BYTE;
      else       RDATA <= next_rdata;
   end

   // -----------------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------------
   // Alternate outputs only reach the pin once the direction bit is 1
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         P1_OUT <= RST_LATCH;
         P1_OE  <= RST_DIR;
      end else begin
         P1_OUT <= (P1_ALT_EN & P1_ALT_VAL) | (~P1_ALT_EN & port_one_latch); // RULE1
         P1_OE  <= port_one_direction; // RULE1 RULE18
      end
   end

   // Port two is pull-down only: a 0 in the latch drives the pin low
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         P2_OUT <= RST_P2;
         P2_OE  <= ~RST_P2;
      end else begin
         P2_OUT <= port_two_output_latch;
         P2_OE  <= ~port_two_output_latch;
         if (dual_mode) begin
            P2_OE[OSC_IN_BIT]  <= 1'b0; // RULE9
            P2_OE[OSC_OUT_BIT] <= 1'b0; // RULE9
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         P3_OUT     <= RST_LATCH;
         P3_OE      <= RST_DIR;
         ANALOG_SEL <= ZERO_BYTE;
      end else begin
         P3_OUT     <= port_three_output_latch;
         P3_OE      <= port_three_direction & ~next_ana; // RULE13 RULE18
         ANALOG_SEL <= next_ana; // RULE13
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         P4_OUT <= RST_LATCH;
         P4_OE  <= RST_DIR;
      end else begin
         P4_OUT <= port_four_latch;
         P4_OE  <= port_four_direction; // RULE16 RULE18
      end
   end

   // -----------------------------------------------------------------
   // Slow oscillator and interrupt edge
   // -----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         SLOW_OSC_EN <= 1'b0;
         SLOW_OSC_IN <= 1'b0;
      end else begin
         SLOW_OSC_EN <= dual_mode; // RULE9
         SLOW_OSC_IN <= dual_mode & P2_IN[OSC_IN_BIT]; // RULE9
      end
   end

   // Edge taken from the pin, so a driven pulse also raises a request
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         p20_prev    <= 1'b0;
         EXT_INT_REQ <= 1'b0;
      end else begin
         p20_prev    <= P2_IN[INT_BIT];
         EXT_INT_REQ <= p20_prev & ~P2_IN[INT_BIT]; // RULE10
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   property p_dir_one;
      ##1 P1_OE == $past(port_one_direction);
   endproperty
   a_dir_one: assert property (p_dir_one) else $error("P1 OE not direction"); // RULE1

   property p_rst_one;
      $fell(RESET) |-> port_one_direction == RST_DIR && port_one_latch == RST_LATCH;
   endproperty
   a_rst_one: assert property (p_rst_one) else $error("P1 reset value"); // RULE2

   property p_latch_wr;
      WR && ADDR == OFS_P4_LATCH |=> port_four_latch == $past(WDATA);
   endproperty
   a_latch_wr: assert property (p_latch_wr) else $error("P4 latch lost write"); // RULE3

   property p_rd_mix;
      RD && ADDR == OFS_P1_LATCH |=>
         RDATA == $past((port_one_direction & port_one_latch)
                        | (~port_one_direction & P1_IN));
   endproperty
   a_rd_mix: assert property (p_rd_mix) else $error("P1 read mix wrong"); // RULE4

   property p_rst_two;
      $fell(RESET) |-> port_two_output_latch == RST_P2;
   endproperty
   a_rst_two: assert property (p_rst_two) else $error("P2 latch reset"); // RULE7

   property p_dual;
      dual_mode |=> P2_OE[OSC_OUT_BIT:OSC_IN_BIT] == 2'h0 && SLOW_OSC_EN;
   endproperty
   a_dual: assert property (p_dual) else $error("Osc pins driven"); // RULE9

   sequence s_p20_fall;
      P2_IN[INT_BIT] ##1 !P2_IN[INT_BIT];
   endsequence
   property p_int_edge;
      s_p20_fall |=> EXT_INT_REQ ##1 !EXT_INT_REQ;
   endproperty
   a_int_edge: assert property (p_int_edge) else $error("Missed P20 edge"); // RULE10

   property p_p2_read;
      RD && ADDR == OFS_P2_LATCH |=>
         RDATA == {{(DW-P2W){1'b0}}, $past(port_two_output_latch)};
   endproperty
   a_p2_read: assert property (p_p2_read) else $error("P2 latch read"); // RULE11

   property p_rst_three;
      $fell(RESET) |-> port_three_direction == RST_DIR
                       && converter_control_one[ANALOG_INPUT_DISABLE_BIT];
   endproperty
   a_rst_three: assert property (p_rst_three) else $error("P3 reset"); // RULE12

   property p_analog;
      analog_on |=> P3_OE[$past(chan)] == 1'b0 && ANALOG_SEL[$past(chan)];
   endproperty
   a_analog: assert property (p_analog) else $error("Analog pin driven"); // RULE13

   property p_dir_four;
      ##1 P4_OE == $past(port_four_direction);
   endproperty
   a_dir_four: assert property (p_dir_four) else $error("P4 OE wrong"); // RULE16 RULE18

   property p_rst_four;
      $fell(RESET) |-> port_four_direction == RST_DIR && port_four_latch == RST_LATCH;
   endproperty
   a_rst_four: assert property (p_rst_four) else $error("P4 reset value"); // RULE17
endmodule

// ### test/gpp_pin_model.sv
/*
 * Board side of one parallel port: merges the block's pin drivers
 * with what the board presents on each pin.
 * Assumes a push-pull pad per bit; a driven bit wins over the board.
 */
module gpp_pin_model
#(
   parameter int W = 8
)
(
   input  wire logic [W-1:0] drv_out,
   input  wire logic [W-1:0] drv_oe,
   input  wire logic [W-1:0] board,
   output logic      [W-1:0] level
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Wire level
   // -----------------------------------------------------------------
   // An undriven pin shows the board level, never the stale latch
   assign level = (drv_oe & drv_out) | (~drv_oe & board);
endmodule

// ### test/general_purpose_ports_one_to_four_tb.sv
/*
 * Self-checking bench for the port block: register bus master, board
 * pin models and a reference model of latches and directions.
 * Assumes the register map and reset values of the shared package.
 */
module general_purpose_ports_one_to_four_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gpp_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic           ref_clk, reset, wr_s, rd_s, osc_en, osc_in, int_req;
   logic [AW-1:0]  addr;
   logic [DW-1:0]  wdata, rdata, alt_en, alt_val, analog_sel, v;
   logic [DW-1:0]  p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe, p4_in, p4_out, p4_oe;
   logic [P2W-1:0] p2_in, p2_out, p2_oe;
   logic [DW-1:0]  ext [1:4];
   logic [DW-1:0]  outs [1:4];
   logic [DW-1:0]  oes [1:4];
   logic [DW-1:0]  mlat [1:4];
   logic [DW-1:0]  mdir [1:4];
   int             err_count, n_tests, cnt;
   int             pl [3] = '{1, 3, 4};
   assign outs[1] = p1_out;
   assign outs[3] = p3_out;
   assign outs[4] = p4_out;
   assign oes[1]  = p1_oe;
   assign oes[3]  = p3_oe;
   assign oes[4]  = p4_oe;
   always #12.5 ref_clk = ~ref_clk;
   gpp_ports dut_u (.REF_CLK(ref_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
      .WR(wr_s), .RD(rd_s), .RDATA(rdata), .P1_IN(p1_in), .P1_OUT(p1_out),
      .P1_OE(p1_oe), .P1_ALT_EN(alt_en), .P1_ALT_VAL(alt_val), .P2_IN(p2_in),
      .P2_OUT(p2_out), .P2_OE(p2_oe), .P3_IN(p3_in), .P3_OUT(p3_out), .P3_OE(p3_oe),
      .P4_IN(p4_in), .P4_OUT(p4_out), .P4_OE(p4_oe), .ANALOG_SEL(analog_sel),
      .SLOW_OSC_EN(osc_en), .SLOW_OSC_IN(osc_in), .EXT_INT_REQ(int_req));
   gpp_pin_model #(.W(DW)) pm1_u (.drv_out(p1_out), .drv_oe(p1_oe), .board(ext[1]),
      .level(p1_in));
   gpp_pin_model #(.W(P2W)) pm2_u (.drv_out(p2_out), .drv_oe(p2_oe),
      .board(ext[2][P2W-1:0]), .level(p2_in));
   gpp_pin_model #(.W(DW)) pm3_u (.drv_out(p3_out), .drv_oe(p3_oe), .board(ext[3]),
      .level(p3_in));
   gpp_pin_model #(.W(DW)) pm4_u (.drv_out(p4_out), .drv_oe(p4_oe), .board(ext[4]),
      .level(p4_in));
   // -----------------------------------------------------------------
   // Bus tasks and reference model
   // -----------------------------------------------------------------
   function automatic logic [AW-1:0] dat_ofs(int k);
      return (k == 1) ? OFS_P1_LATCH : (k == 3) ? OFS_P3_LATCH : OFS_P4_LATCH;
   endfunction
   function automatic logic [AW-1:0] dir_ofs(int k);
      return (k == 1) ? OFS_P1_DIR : (k == 3) ? OFS_P3_DIR : OFS_P4_DIR;
   endfunction
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge ref_clk);
      wr_s <= 1'b0;
      foreach (pl[i]) begin
         if (a == dat_ofs(pl[i])) mlat[pl[i]] = d;
         if (a == dir_ofs(pl[i])) mdir[pl[i]] = d;
      end
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic count_irq();
      cnt = 0;
      repeat (8) begin
         @(posedge ref_clk);
         #1 if (int_req === 1'b1) cnt++;
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      #(25ns * 4000);
      err_count++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      {wr_s, rd_s, addr, wdata, alt_en, alt_val} = '0;
      ext = '{default: ONES_BYTE};
      mlat = '{default: RST_LATCH};
      mdir = '{default: RST_DIR};
      void'($urandom(32'hba677c4c));
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      #1 `CHK(p1_oe | p3_oe | p4_oe, RST_DIR)
      `CHK(p1_out | p4_out, RST_LATCH)
      `CHK(p2_out, RST_P2)
      rd(OFS_CONV1, v);
      `CHK(v, RST_CONV1)
      rd(6'h05, v);
      `CHK(v, ZERO_BYTE)
      $display("reset test done");
      // Latch preload, direction mix, read-back and write-back of the read byte
      foreach (pl[i]) begin
         @(posedge ref_clk);
         ext[pl[i]] <= $urandom;
         wr(dat_ofs(pl[i]), $urandom);
         @(posedge ref_clk);
         #1 `CHK(outs[pl[i]], mlat[pl[i]])
         wr(dir_ofs(pl[i]), $urandom);
         @(posedge ref_clk);
         #1 `CHK(oes[pl[i]], mdir[pl[i]])
         rd(dir_ofs(pl[i]), v);
         `CHK(v, mdir[pl[i]])
         rd(dat_ofs(pl[i]), v);
         `CHK(v, (mlat[pl[i]] & mdir[pl[i]]) | (ext[pl[i]] & ~mdir[pl[i]]))
         wr(dat_ofs(pl[i]), v);
         @(posedge ref_clk);
         #1 `CHK(outs[pl[i]], v)
      end
      $display("port data test done");
      wr(OFS_P1_LATCH, ONES_BYTE);
      wr(OFS_P1_DIR, ONES_BYTE);
      alt_val <= $urandom;
      alt_en <= $urandom;
      repeat (2) @(posedge ref_clk);
      #1 `CHK(p1_out, (alt_en & alt_val) | (~alt_en & mlat[1]))
      $display("alternate output test done");
      @(posedge ref_clk);
      alt_en <= ZERO_BYTE;
      ext[2] <= $urandom | 8'h01;
      rd(OFS_P2_LATCH, v);
      `CHK(v, 8'h07)
      wr(OFS_P2_LATCH, 8'hfd);
      rd(OFS_P2_PINS, v);
      `CHK(v, ext[2] & 8'h05)
      rd(OFS_P2_LATCH, v);
      `CHK(v, 8'h05)
      // Oscillator pin latches set to one before dual mode, which turns their drivers off by itself
      wr(OFS_P2_LATCH, 8'h07);
      wr(OFS_CLKMODE, 8'h01);
      @(posedge ref_clk);
      #1 `CHK({osc_en, p2_oe[2:1]}, 3'b100)
      `CHK(osc_in, ext[2][1])
      wr(OFS_CLKMODE, RST_MODE);
      @(posedge ref_clk);
      #1 `CHK({osc_en, p2_oe}, 4'b0000)
      wr(OFS_P2_LATCH, 8'h07);
      $display("port two test done");
      @(posedge ref_clk);
      ext[2] <= ext[2] & 8'hfe;
      count_irq();
      `CHK(cnt, 1)
      @(posedge ref_clk);
      ext[2] <= ext[2] | 8'h01;
      repeat (3) @(posedge ref_clk);
      wr(OFS_P2_LATCH, 8'h06);
      count_irq();
      `CHK(cnt, 1)
      wr(OFS_P2_LATCH, 8'h07);
      $display("interrupt test done");
      // Port three latch stays untouched while a channel converts
      @(posedge ref_clk);
      ext[3] <= $urandom;
      wr(OFS_P3_DIR, ONES_BYTE);
      for (int ch = 0; ch < 8; ch++) begin
         wr(OFS_CONV1, 8'(ch));
         @(posedge ref_clk);
         #1 `CHK(analog_sel, 8'h01 << ch)
         `CHK(p3_oe, ~(8'h01 << ch))
         rd(OFS_P3_LATCH, v);
         `CHK(v, (mlat[3] & ~(8'h01 << ch)) | (ext[3] & (8'h01 << ch)))
      end
      wr(OFS_CONV1, RST_CONV1);
      @(posedge ref_clk);
      #1 `CHK({analog_sel, p3_oe}, {ZERO_BYTE, ONES_BYTE})
      $display("analog test done");
      complete_run();
   end
endmodule
